// file: logic/dmarg_pkg.sv
// Constants and types for the DMA request generation block.
// Assumes one 25 MHz clock and a transfer engine outside that runs bus cycles.
package dmarg_pkg;
    //--------------------------------------------------------------
    // Sizes
    //--------------------------------------------------------------
    localparam int NCH = 4;                       // Channel count
    localparam logic [3:0] IVL_BASE = 4'h5;       // Interval exponent offset
    localparam logic [3:0] WIN_BASE = 4'h4;       // Window exponent offset
    localparam logic [1:0] HOLD_IVLS = 2'h2;      // Interval ends to hold
    //--------------------------------------------------------------
    // Field codes
    //--------------------------------------------------------------
    localparam logic [1:0] RG_LIMITED = 2'h0;     // Limited-rate auto
    localparam logic [1:0] RG_MAXIMUM = 2'h1;     // Maximum-rate auto
    localparam logic [1:0] RG_EXTERN  = 2'h2;     // External request line
    localparam logic [1:0] RG_MIXED   = 2'h3;     // Auto first, then external
    localparam logic [1:0] XM_BURST   = 2'h0;     // Burst request
    localparam logic [1:0] XM_STEAL   = 2'h2;     // Cycle steal, no hold
    localparam logic [1:0] XM_HOLD    = 2'h3;     // Cycle steal with hold
    localparam logic [1:0] DT_WORD    = 2'h0;     // Addressed 16-bit device
    localparam logic [1:0] DT_BYTE    = 2'h1;     // Addressed 8-bit device
    localparam logic [1:0] DT_ACKSEL  = 2'h2;     // Acknowledge-selected device
    //--------------------------------------------------------------
    // Reset values
    //--------------------------------------------------------------
    localparam logic [3:0] RST_PIN_N = 4'hF;      // Request pins idle high
    //--------------------------------------------------------------
    // Types
    //--------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SERVE = 3'h2,
        ST_HOLD  = 3'h4
    } dmarg_state_t;
    typedef struct packed {
        logic [3:0]   req_s1;    // Request synchroniser stage one
        logic [3:0]   req_s2;    // Request synchroniser stage two
        logic [3:0]   req_d;     // Previous synchronised request
        logic         bg_s1;     // Grant-ack stage one
        logic         bg_s2;     // Grant-ack stage two
        logic [10:0]  cnt;       // Position in interval
        logic [11:0]  busy;      // DMA-used clocks this interval
        logic         allow;     // Limited requests allowed
        logic         window;    // Inside limited window
        logic [3:0]   act;       // Channel running
        logic [3:0]   first;     // Mixed mode first transfer due
        logic [3:0]   edge_f;    // Captured falling edge
        logic [3:0]   opb;       // Operand access in progress
        logic [1:0]   rr;        // Last served channel
        dmarg_state_t st;        // Sequencer state
        logic [1:0]   ch;        // Channel in service
        logic         auto_svc;  // Service came from limited or maximum-rate auto request
        logic [1:0]   hold_n;    // Interval ends seen in hold
        logic         svc;       // Service request to engine
        logic [3:0]   ack_n;     // Acknowledge lines
        logic         high_byte_indicator;    // High byte indicator
        logic         done_n;    // Done line
        logic         own;       // Bus wanted
    } dmarg_regs_t;
endpackage

// file: logic/dmarg_top.sv
// Request generation and recognition for four DMA channels.
// Assumes an engine that runs bus cycles and pulses begin/done per operand.
`timescale 1ns/1ps
module dmarg_top (
    // Clock and reset
    input  wire logic                        CLK_I,
    input  wire logic                        RST_I,
    // Pins
    input  wire logic [dmarg_pkg::NCH-1:0]   REQ_N_I,
    input  wire logic                        BGACK_N_I,
    // Global configuration
    input  wire logic [1:0]                  BURST_TIME_FIELD_I,
    input  wire logic [1:0]                  BANDWIDTH_RATIO_FIELD_I,
    // Channel configuration, two bits per channel
    input  wire logic [2*dmarg_pkg::NCH-1:0] REQUEST_GENERATION_FIELD_I,
    input  wire logic [2*dmarg_pkg::NCH-1:0] EXTERNAL_REQUEST_MODE_FIELD_I,
    input  wire logic [2*dmarg_pkg::NCH-1:0] DEVICE_TYPE_FIELD_I,
    input  wire logic [2*dmarg_pkg::NCH-1:0] PRIORITY_I,
    // Engine status
    input  wire logic [dmarg_pkg::NCH-1:0]   START_I,
    input  wire logic [dmarg_pkg::NCH-1:0]   COUNT_DONE_I,
    input  wire logic [dmarg_pkg::NCH-1:0]   MULTI_ACCESS_I,
    input  wire logic                        LAST_BEGIN_I,
    input  wire logic                        XFER_DONE_I,
    input  wire logic                        HIGH_BYTE_INDICATOR_I,
    input  wire logic                        DONE_REQ_I,
    // Outputs
    output logic                             BUS_REQ_O,
    output logic                             SVC_VALID_O,
    output logic [1:0]                       SVC_CH_O,
    output logic [dmarg_pkg::NCH-1:0]        ACK_N_O,
    output logic                             HIGH_BYTE_INDICATOR_O,
    output logic                             DONE_N_O,
    output logic                             LIMITED_RATE_REQUEST_WINDOW_O
);
    import dmarg_pkg::*;

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    dmarg_regs_t r_r;                 // Registered state
    dmarg_regs_t r_nxt;               // Next state
    logic [10:0] len_m1;              // Interval length minus one
    logic [11:0] win_len;             // Window length, also busy limit
    logic        ivl_end;             // Last clock of interval
    logic [3:0]  pend;                // Request pending per channel
    logic [3:0]  fall;                // Falling edge per channel
    logic [3:0]  auto_p;              // Pending from auto request
    logic        any_p;               // Any pending
    logic [1:0]  pick;                // Arbiter winner
    logic [1:0]  best;                // Best priority level

    //------------------------------------------------------------------
    // Interval arithmetic
    //------------------------------------------------------------------
    always_comb begin
        // Length is two to bt+br+5; window two to bt+4
        len_m1  = 11'(({8'h00, 4'h1} << (IVL_BASE + 4'(BURST_TIME_FIELD_I)
                  + 4'(BANDWIDTH_RATIO_FIELD_I))) - 12'h001);
        win_len = 12'h001 << (WIN_BASE + 4'(BURST_TIME_FIELD_I));
        // Interval ends on its last clock
        ivl_end = (r_r.cnt == len_m1);
    end

    //------------------------------------------------------------------
    // Per-channel request recognition
    //------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            // Falling edge seen on synchronised line
            fall[c]   = r_r.req_d[c] & ~r_r.req_s2[c];
            auto_p[c] = 1'b0;
            pend[c]   = 1'b0;
            // Auto source chosen by generation mode
            case (REQUEST_GENERATION_FIELD_I[2*c +: 2])
                RG_LIMITED: auto_p[c] = r_r.act[c] & r_r.allow & r_r.window;
                RG_MAXIMUM: auto_p[c] = r_r.act[c];
                RG_MIXED:   auto_p[c] = r_r.act[c] & r_r.first[c];
                default:    auto_p[c] = 1'b0;
            endcase
            // External line, also for mixed after first
            if (REQUEST_GENERATION_FIELD_I[2*c +: 2] == RG_EXTERN ||
                (REQUEST_GENERATION_FIELD_I[2*c +: 2] == RG_MIXED && !r_r.first[c])) begin
                if (EXTERNAL_REQUEST_MODE_FIELD_I[2*c +: 2] == XM_STEAL ||
                    EXTERNAL_REQUEST_MODE_FIELD_I[2*c +: 2] == XM_HOLD) begin
                    // Steal modes wait for a captured edge
                    pend[c] = r_r.act[c] & r_r.edge_f[c];
                end else begin
                    // Burst follows the synchronised level
                    pend[c] = r_r.act[c] & ~r_r.req_s2[c];
                end
            end
            // Either source leaves the channel pending
            pend[c] = pend[c] | auto_p[c];
        end
        any_p = |pend;
    end

    //------------------------------------------------------------------
    // Arbiter: best level, then round robin from last served
    //------------------------------------------------------------------
    always_comb begin
        logic [1:0] k;
        k    = 2'h0;
        best = 2'h3;
        pick = r_r.rr;
        // Lowest value among pending is the best level
        for (int c = NCH - 1; c >= 0; c--) begin
            if (pend[c] && PRIORITY_I[2*c +: 2] <= best) begin
                best = PRIORITY_I[2*c +: 2];
            end
        end
        // Last hit wins, so the nearest after the last served is taken
        for (int i = NCH; i >= 1; i--) begin
            k = 2'(r_r.rr + 2'(i));
            if (pend[k] && PRIORITY_I[2*k +: 2] == best) begin
                pick = k;
            end
        end
    end

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        // Hold everything unless changed below
        r_nxt        = r_r;
        // Two-flop synchronisers for the pins
        r_nxt.req_s1 = REQ_N_I;
        r_nxt.req_s2 = r_r.req_s1;
        r_nxt.req_d  = r_r.req_s2;
        r_nxt.bg_s1  = BGACK_N_I;
        r_nxt.bg_s2  = r_r.bg_s1;
        // Sample interval and utilisation
        if (ivl_end) begin
            // Judge utilisation, this clock included
            r_nxt.cnt   = 11'h000;
            r_nxt.busy  = 12'h000;
            r_nxt.allow = ((r_r.busy + {11'h000, ~r_r.bg_s2}) <= win_len);
        end else begin
            // Otherwise count on and add busy clocks
            r_nxt.cnt  = 11'(r_r.cnt + 11'h001);
            r_nxt.busy = 12'(r_r.busy + {11'h000, ~r_r.bg_s2});
        end
        // Window high for the first part of the interval
        r_nxt.window = ({1'b0, r_nxt.cnt} < win_len);
        // Channel flags
        for (int c = 0; c < NCH; c++) begin
            // Count exhausted stops the channel
            if (COUNT_DONE_I[c]) begin
                r_nxt.act[c] = 1'b0;
            end
            // Start wins over a stop in the same clock
            if (START_I[c]) begin
                r_nxt.act[c]   = 1'b1;
                r_nxt.first[c] = (REQUEST_GENERATION_FIELD_I[2*c +: 2] == RG_MIXED);
                r_nxt.edge_f[c] = 1'b0;
            end
            // Last device access begun: edges count again
            if (LAST_BEGIN_I && r_r.ch == 2'(c)) begin
                r_nxt.opb[c] = 1'b0;
            end
        end
        // Sequencer
        case (r_r.st)
            ST_IDLE, ST_HOLD: begin
                // Hold ends at the second interval boundary
                if (r_r.st == ST_HOLD && ivl_end) begin
                    r_nxt.hold_n = 2'(r_r.hold_n + 2'h1);
                    if (2'(r_r.hold_n + 2'h1) == HOLD_IVLS) begin
                        r_nxt.st = ST_IDLE;
                    end
                end
                // Grant the arbiter's pick
                if (any_p) begin
                    r_nxt.st       = ST_SERVE;
                    r_nxt.ch       = pick;
                    r_nxt.rr       = pick;
                    r_nxt.svc      = 1'b1;
                    // Mixed first transfer counts as external
                    r_nxt.auto_svc = auto_p[pick] &
                        (REQUEST_GENERATION_FIELD_I[2*pick +: 2] != RG_MIXED);
                    r_nxt.first[pick] = 1'b0;
                    // Multi-access dual-address operand blocks edges
                    r_nxt.opb[pick] = MULTI_ACCESS_I[pick] &
                        (DEVICE_TYPE_FIELD_I[2*pick +: 2] != DT_ACKSEL);
                    // Quiet acknowledge for addressed 16-bit device in auto mode
                    if (!(r_nxt.auto_svc &&
                          DEVICE_TYPE_FIELD_I[2*pick +: 2] == DT_WORD)) begin
                        r_nxt.ack_n[pick] = 1'b0;
                    end
                end
            end
            ST_SERVE: begin
                // Service pulse lasts one clock
                r_nxt.svc    = 1'b0;
                // Engine values pass, quiet in memory mode
                r_nxt.high_byte_indicator = HIGH_BYTE_INDICATOR_I & ~(r_r.auto_svc &&
                    DEVICE_TYPE_FIELD_I[2*r_r.ch +: 2] == DT_WORD);
                r_nxt.done_n = ~(DONE_REQ_I & ~(r_r.auto_svc &&
                    DEVICE_TYPE_FIELD_I[2*r_r.ch +: 2] == DT_WORD));
                // Operand done: acknowledge off, then hold or idle
                if (XFER_DONE_I) begin
                    r_nxt.ack_n  = 4'hF;
                    r_nxt.high_byte_indicator = 1'b0;
                    r_nxt.done_n = 1'b1;
                    r_nxt.hold_n = 2'h0;
                    if (EXTERNAL_REQUEST_MODE_FIELD_I[2*r_r.ch +: 2] == XM_HOLD &&
                        !r_r.auto_svc) begin
                        // Keep the bus and wait for another edge
                        r_nxt.st = ST_HOLD;
                    end else begin
                        // Release the bus
                        r_nxt.st = ST_IDLE;
                    end
                end
            end
            // Unknown code falls back to idle
            default: r_nxt.st = ST_IDLE;
        endcase
        // Edge capture; set wins over the clear of a grant
        for (int c = 0; c < NCH; c++) begin
            // Grant consumes the edge
            if (r_r.st != ST_SERVE && any_p && pick == 2'(c)) begin
                r_nxt.edge_f[c] = 1'b0;
            end
            // New edge, unless an operand is in progress
            if (fall[c] && !r_nxt.opb[c] && !r_r.opb[c]) begin
                r_nxt.edge_f[c] = 1'b1;
            end
        end
        // Bus stays wanted while serving, holding or pending
        r_nxt.own = (r_nxt.st != ST_IDLE) || any_p;
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    // Asynchronous reset, else take the next state
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            // Pins idle, acknowledge and done inactive
            r_r <= '{req_s1: RST_PIN_N, req_s2: RST_PIN_N, req_d: RST_PIN_N,
                     bg_s1: 1'b1, bg_s2: 1'b1, allow: 1'b1, window: 1'b1,
                     st: ST_IDLE, ack_n: RST_PIN_N, done_n: 1'b1, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // All outputs come straight from the state register
    assign BUS_REQ_O   = r_r.own;
    assign SVC_VALID_O = r_r.svc;
    assign SVC_CH_O    = r_r.ch;
    assign ACK_N_O     = r_r.ack_n;
    assign HIGH_BYTE_INDICATOR_O    = r_r.high_byte_indicator;
    assign DONE_N_O    = r_r.done_n;
    assign LIMITED_RATE_REQUEST_WINDOW_O = r_r.window;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    // Steps of an interval wrap
    sequence at_end_s;
        ivl_end;
    endsequence
    sequence restart_s;
        r_r.cnt == 11'h000;
    endsequence
    interval_wrap_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        at_end_s |=> restart_s) else $error("interval did not restart");
    interval_len_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        ivl_end |-> ({1'b0, r_r.cnt} + 12'h001 ==
        (12'h001 << (IVL_BASE + 4'(BURST_TIME_FIELD_I) + 4'(BANDWIDTH_RATIO_FIELD_I)))))
        else $error("interval length wrong");
    window_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.svc && REQUEST_GENERATION_FIELD_I[2*r_r.ch +: 2] == RG_LIMITED)
        |-> $past(r_r.window && r_r.allow)) else $error("limited request outside window");
    suppress_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (ivl_end && r_r.busy > win_len) |=> !r_r.allow)
        else $error("heavy use not suppressed");
    ack_quiet_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.st == ST_SERVE && r_r.auto_svc &&
         DEVICE_TYPE_FIELD_I[2*r_r.ch +: 2] == DT_WORD) |-> (r_r.ack_n == 4'hF && r_r.done_n))
        else $error("acknowledge active in memory mode");
    hold_bus_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.st == ST_HOLD) |-> r_r.own) else $error("bus dropped in hold");
    hold_ack_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.st == ST_HOLD && any_p) |-> ##[1:2] (r_r.ack_n != 4'hF || r_r.auto_svc
        || DEVICE_TYPE_FIELD_I[2*r_r.ch +: 2] == DT_WORD))
        else $error("late acknowledge in hold");
    ignore_edge_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.opb[0] && !r_r.edge_f[0] && r_r.st == ST_SERVE) |=> !r_r.edge_f[0])
        else $error("edge taken during operand");
    release_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.st == ST_SERVE && XFER_DONE_I &&
         EXTERNAL_REQUEST_MODE_FIELD_I[2*r_r.ch +: 2] == XM_STEAL)
        |=> (r_r.st != ST_HOLD)) else $error("steal without hold kept bus");
    max_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (r_r.st == ST_SERVE && r_r.act[r_r.ch] &&
         REQUEST_GENERATION_FIELD_I[2*r_r.ch +: 2] == RG_MAXIMUM) |=> r_r.own)
        else $error("maximum rate dropped the bus");
endmodule // dmarg_top

// file: verif/dmarg_engine_model.sv
// Engine and system bus model facing the request block.
// Assumes one clock; each service is answered after a set delay.
`timescale 1ns/1ps
module dmarg_engine_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // From the block
    input  wire logic       bus_req_i,
    input  wire logic       svc_valid_i,
    input  wire logic [3:0] delay_i,
    // To the block
    output logic            bgack_n_o,
    output logic            last_begin_o,
    output logic            xfer_done_o
);
    logic [3:0] left_r;     // Clocks left in the operand

    //----------------------------------------
    // Grant follows the request; done after the delay
    //----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bgack_n_o    <= 1'b1;
            last_begin_o <= 1'b0;
            xfer_done_o  <= 1'b0;
            left_r       <= 4'h0;
        end else begin
            // Bus taken one clock after it is wanted
            bgack_n_o    <= ~bus_req_i;
            // Last access begins one clock before completion
            last_begin_o <= (left_r == 4'h2);
            xfer_done_o  <= (left_r == 4'h1);
            if (svc_valid_i) begin
                left_r <= delay_i;
            end else if (left_r != 4'h0) begin
                left_r <= left_r - 4'h1;
            end
        end
    end
endmodule // dmarg_engine_model

// file: verif/tb.sv
// Self-checking bench for the DMA request generation block.
// Assumes the engine model beside it answers every service.
`timescale 1ns/1ps
module tb;
    import dmarg_pkg::*;
    //----------------------------------------
    // Signals
    //----------------------------------------
    logic        clk, rst;               // Clock and reset
    logic [3:0]  req_n, start, cdone, multi; // Pins, pulses, multi-access
    logic [1:0]  bt, br;                 // Interval fields
    logic [7:0]  rg, external_request_mode_field, dt, pri;       // Channel fields
    logic [3:0]  delay;                  // Engine answer delay
    logic        bgack_n, last_b, xdone; // Engine model outputs
    logic        bus_req, svc, hib;      // Block outputs
    logic        done_n, win, prev;      // Block outputs, last channel
    logic [1:0]  svc_ch;                 // Channel in service
    logic [3:0]  ack_n;                  // Acknowledge lines
    int          mismatches, checked;    // Result counters
    int          cycles, n, c, hits, late; // Timeout and work counts

    dmarg_top dmarg_top_inst (.CLK_I(clk), .RST_I(rst), .REQ_N_I(req_n),
        .BGACK_N_I(bgack_n), .BURST_TIME_FIELD_I(bt), .BANDWIDTH_RATIO_FIELD_I(br),
        .REQUEST_GENERATION_FIELD_I(rg), .EXTERNAL_REQUEST_MODE_FIELD_I(external_request_mode_field),
        .DEVICE_TYPE_FIELD_I(dt), .PRIORITY_I(pri), .START_I(start),
        .COUNT_DONE_I(cdone), .MULTI_ACCESS_I(multi), .LAST_BEGIN_I(last_b),
        .XFER_DONE_I(xdone), .HIGH_BYTE_INDICATOR_I(1'b1), .DONE_REQ_I(1'b1), .BUS_REQ_O(bus_req),
        .SVC_VALID_O(svc), .SVC_CH_O(svc_ch), .ACK_N_O(ack_n), .HIGH_BYTE_INDICATOR_O(hib),
        .DONE_N_O(done_n), .LIMITED_RATE_REQUEST_WINDOW_O(win));
    dmarg_engine_model dmarg_engine_model_inst (.clk_i(clk), .rst_i(rst),
        .bus_req_i(bus_req), .svc_valid_i(svc), .delay_i(delay),
        .bgack_n_o(bgack_n), .last_begin_o(last_b), .xfer_done_o(xdone));

    //----------------------------------------
    // Clock and hang guard
    //----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    //----------------------------------------
    // Access and compare tasks
    //----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Program all channels, then reset for two clocks
    task automatic setup(input logic [7:0] g, x, d, p);
        rg = g;
        external_request_mode_field = x;
        dt = d;
        pri = p;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
    endtask
    task automatic pulse(input logic [3:0] s, input logic [3:0] d);
        start = s;
        cdone = d;
        tick(1);
        start = 4'h0;
        cdone = 4'h0;
    endtask
    task automatic wait_svc(output int k);
        k = 0;
        while (svc !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
    endtask
    task automatic ack_off(output int k);
        k = 0;
        while (ack_n !== 4'hF && k < 40) begin
            tick(1);
            k++;
        end
    endtask
    task automatic count_svc(input int len, output int k);
        k = 0;
        repeat (len) begin
            tick(1);
            if (svc === 1'b1) k++;
        end
    endtask
    task automatic run_len(input logic lvl, output int k);
        k = 0;
        while (win === lvl && k < 3000) begin
            tick(1);
            k++;
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    //----------------------------------------
    // Test sequence
    //----------------------------------------
    initial begin
        rst = 1'b1;
        {req_n, start, cdone, delay, bt, br} = {4'hF, 4'h0, 4'h0, 4'h3, 2'h0, 2'h0};
        {rg, external_request_mode_field, dt, pri} = {8'hAA, 8'h00, 8'hAA, 8'h00};
        multi = 4'h0;
        tick(1);
        check("reset outputs", 16'h007B, {7'h00, bus_req, svc, ack_n, hib, done_n, win});
        // Interval and window lengths for three field pairs
        for (int i = 0; i < 3; i++) begin
            bt = i[1:0];
            br = (i == 1) ? 2'h1 : 2'h0;
            setup(8'hAA, 8'h00, 8'hAA, 8'h00);
            run_len(1'b1, n);
            run_len(1'b0, n);
            run_len(1'b1, c);
            check("window gap", 16'((1 << (bt + br + 5)) - (1 << (bt + 4))), 16'(n));
            check("window length", 16'(1 << (bt + 4)), 16'(c));
        end
        bt = 2'h0;
        br = 2'h0;
        // Limited rate with a slow engine: every other window suppressed
        delay = 4'h9;
        setup(8'hA8, 8'h00, 8'hAA, 8'h00);
        pulse(4'h1, 4'h0);
        {hits, late} = {32'd0, 32'd0};
        run_len(1'b1, n);
        run_len(1'b0, n);
        // One pass per interval; a busy interval suppresses the next one
        for (int k = 0; k < 8; k++) begin
            count_svc(18, c);
            hits += (c > 0);
            count_svc(14, c);
            late += c;
        end
        check("allowed windows", 16'h0004, 16'(hits));
        check("late limited", 16'h0000, 16'(late));
        // Cycle steal without hold on channel 0
        delay = 4'h3;
        setup(8'hAA, 8'h02, 8'hAA, 8'h00);
        pulse(4'h1, 4'h0);
        req_n[0] = 1'b0;
        wait_svc(n);
        check("steal wait", 16'h0001, 16'(n <= 8));
        check("steal ack", 16'h000E, {12'h000, ack_n});
        tick(1);
        count_svc(30, c);
        check("steal once", 16'h0000, 16'(c));
        check("steal release", 16'h0000, {15'h0000, bus_req});
        req_n[0] = 1'b1;
        // Multi-access byte device on channel 0: edges inside the operand dropped
        delay = 4'h9;
        multi = 4'h1;
        setup(8'hAA, 8'h02, 8'hA9, 8'h00);
        pulse(4'h1, 4'h0);
        req_n[0] = 1'b0;
        wait_svc(n);
        req_n[0] = 1'b1;
        tick(2);
        req_n[0] = 1'b0;
        count_svc(30, c);
        check("operand edge", 16'h0000, 16'(c));
        {req_n[0], multi, delay} = {1'b1, 4'h0, 4'h3};
        // Burst on channel 1, then released early
        setup(8'hAA, 8'h00, 8'hAA, 8'h00);
        pulse(4'h2, 4'h0);
        req_n[1] = 1'b0;
        count_svc(40, c);
        check("burst repeats", 16'h0001, 16'(c >= 3));
        req_n[1] = 1'b1;
        tick(8);
        count_svc(30, c);
        check("burst stops", 16'h0000, 16'(c));
        // Cycle steal with hold on channel 2
        setup(8'hAA, 8'h30, 8'hAA, 8'h00);
        pulse(4'h4, 4'h0);
        req_n[2] = 1'b0;
        tick(2);
        req_n[2] = 1'b1;
        wait_svc(n);
        ack_off(n);
        tick(10);
        req_n[2] = 1'b0;
        wait_svc(n);
        check("hold answer", 16'h0001, 16'(n <= 8));
        req_n[2] = 1'b1;
        ack_off(n);
        pulse(4'h0, 4'h4);
        n = 0;
        while (bus_req === 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check("hold span", 16'h0001, 16'(n >= 30 && n <= 68));
        // Maximum rate on channels 0 and 1, addressed 16-bit devices
        setup(8'hA5, 8'h00, 8'hA0, 8'h00);
        pulse(4'h3, 4'h0);
        for (int k = 0; k < 4; k++) begin
            wait_svc(n);
            check("auto quiet", 16'h003D, {10'h000, ack_n, hib, done_n});
            if (k > 0) check("rotation", {15'h0000, ~prev}, {14'h0000, svc_ch});
            prev = svc_ch[0];
            tick(1);
            check("max holds", 16'h0001, {15'h0000, bus_req});
        end
        // Higher priority channel 3 first, channel 0 after it stops
        setup(8'h69, 8'h00, 8'hAA, 8'h01);
        pulse(4'h9, 4'h0);
        for (int k = 0; k < 3; k++) begin
            wait_svc(n);
            check("high first", 16'h0037, {10'h000, svc_ch, ack_n});
            tick(1);
        end
        pulse(4'h0, 4'h8);
        wait_svc(n);
        check("low resumes", 16'h000E, {10'h000, svc_ch, ack_n});
        // Mixed mode on channel 1
        setup(8'hAE, 8'h08, 8'hAA, 8'h00);
        pulse(4'h2, 4'h0);
        wait_svc(n);
        check("mixed first", 16'h001D, {10'h000, svc_ch, ack_n});
        tick(1);
        count_svc(30, c);
        check("mixed waits", 16'h0000, 16'(c));
        req_n[1] = 1'b0;
        tick(2);
        req_n[1] = 1'b1;
        wait_svc(n);
        check("mixed ext", 16'h001D, {10'h000, svc_ch, ack_n});
        stop_test();
    end
endmodule // tb
